// [llc_defs.vh]
// Constants of the latching limit controller.
`ifndef LLC_DEFS_VH
`define LLC_DEFS_VH

// Register byte offsets.
`define LLC_OFS_CTRL 7'h00
`define LLC_OFS_SETPOINT 7'h04
`define LLC_OFS_STATUS 7'h08
`define LLC_OFS_EXCEED_TIME 7'h0c
`define LLC_OFS_PEAK 7'h10
`define LLC_OFS_IRQ_STATUS 7'h14
`define LLC_OFS_IRQ_MASK 7'h18
`define LLC_OFS_DI_CFG 7'h1c
`define LLC_OFS_ALM_CFG0 7'h20
`define LLC_OFS_ALM_SP0 7'h30

// Control register fields.
`define LLC_CTRL_LOW_MODE 0
`define LLC_CTRL_ACK_SRC 1
`define LLC_CTRL_ALM_RELEASE 2

// Status register fields.
`define LLC_ST_EXCEED 0
`define LLC_ST_TRIP 1
`define LLC_ST_RELAY 2
`define LLC_ST_ALARM_LSB 3
`define LLC_ST_PV_RED 6
`define LLC_ST_BACKLIGHT 7

// Interrupt status fields.
`define LLC_IRQ_TRIP 0
`define LLC_IRQ_EXCEED 1
`define LLC_IRQ_ALARM_LSB 2
`define LLC_IRQ_WIDTH 5

// Alarm configuration fields.
`define LLC_ALM_TYPE_MSB 3
`define LLC_ALM_STANDBY 4
`define LLC_ALM_LATCH 5
`define LLC_ALM_HYST_LSB 8
`define LLC_ALM_ON_LSB 16
`define LLC_ALM_OFF_LSB 24

// Alarm types.
`define LLC_AT_OFF 4'h0
`define LLC_AT_PV_HIGH 4'h1
`define LLC_AT_PV_LOW 4'h2
`define LLC_AT_DEV_HIGH 4'h3
`define LLC_AT_DEV_LOW 4'h4
`define LLC_AT_DEV_OUT 4'h5
`define LLC_AT_DEV_IN 4'h6
`define LLC_AT_RATE 4'h7
`define LLC_AT_DIAG 4'h8
`define LLC_AT_FAIL 4'h9

// Contact input function codes.
`define LLC_DI_NONE 3'h0
`define LLC_DI_ALM_RELEASE 3'h1
`define LLC_DI_PV_COLOUR 3'h2
`define LLC_DI_BACKLIGHT 3'h3
`define LLC_DI_MSG1 3'h4

// Reset values.
`define LLC_RST_CTRL 3'h0
`define LLC_RST_SETPOINT 16'h0000
`define LLC_RST_PEAK 16'h8000
`define LLC_RST_DI_CFG 12'h000
`define LLC_RST_ALM_CFG 32'h00000000
`define LLC_RST_ALM_SP 16'h0000

// Time base tick in microseconds, clock in MHz.
`define LLC_TICK_US 1000
`define LLC_CLK_MHZ 100
`define LLC_TICK_CYCLES (`LLC_TICK_US * `LLC_CLK_MHZ)

`endif

// [llc_top.v]
// Latching limit controller with alarms, contact I/O and an Avalon-MM register slave.
// Behaviour
// - Mode bit selects high-limit or low-limit action against one setpoint.
// - Passing the setpoint lights exceed and sets the latched trip together.
// - Relay de-energizes at the moment a trip is set.
// - Exceed clears by itself once the value is back on the normal side.
// - Trip stays set after return to normal until a valid acknowledge.
// - Acknowledge while normal clears the trip.
// - Acknowledge while still beyond the setpoint is ignored.
// - Relay is de-energized whenever trip is set, energized only when clear.
// - De-energized relay leaves normally-closed contact closed, normally-open open.
// - Acknowledge comes from front key or contact, chosen by source select.
// - External acknowledge is always contact input one, fixed.
// - Total time spent beyond the setpoint is accumulated.
// - Highest process value seen is retained and updated on new highs.
// - Three alarms, each driving its own contact output.
// - Alarm types: value high/low, deviation high/low, out/in band, rate.
// - Self-diagnosis and failure conditions are selectable alarm types.
// - Alarms offer standby, forced-reset latch, hysteresis, on and off delays.
// - Contact inputs release latches, toggle colour, backlight, select four messages.
`default_nettype none
`include "llc_defs.vh"

module llc_top #(
    parameter TICK_CYCLES = `LLC_TICK_CYCLES,
    parameter NUM_ALARMS = 3
) (
    input wire ref_clk, // System clock, 100 MHz.
    input wire rst, // Asynchronous reset, active high.
    input wire [6:0] avs_address, // Byte address.
    input wire avs_read, // Read request.
    input wire avs_write, // Write request.
    input wire [31:0] avs_writedata, // Write data.
    output wire [31:0] avs_readdata, // Read data.
    output wire avs_waitrequest, // Stall while high.
    input wire [15:0] process_value, // Signed measured value, same clock.
    input wire self_diag_fault, // Self-diagnosis fault level, same clock.
    input wire input_fail, // Input failure level, same clock.
    input wire ack_key, // Front acknowledge key pin.
    input wire [3:0] contact_input, // Contact input pins; bit 0 is contact_input_one.
    output wire exceed_lamp, // Process value beyond setpoint.
    output wire trip_lamp, // Latched trip.
    output wire relay_energize, // Limit relay coil energized.
    output wire relay_nc_closed, // Normally-closed contact state.
    output wire relay_no_closed, // Normally-open contact state.
    output wire [2:0] alarm_out, // Alarm contact outputs.
    output wire pv_red, // Process display in red.
    output wire backlight_on, // Display backlight on.
    output wire [2:0] message_sel, // Message display 1 to 4, zero for none.
    output wire irq // Level interrupt.
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Whether a rising allocatable contact carries a function code.
    function di_has;
        input [11:0] cfg;
        input [2:0] rise;
        input [2:0] code;
        integer k;
        begin
            di_has = 1'b0;
            for (k = 0; k < 3; k = k + 1) begin
                if (rise[k] && cfg[4*k +: 3] == code) begin
                    di_has = 1'b1;
                end
            end
        end
    endfunction

    // One alarm condition, with hysteresis.
    function alm_eval;
        input [3:0] typ;
        input signed [17:0] pv;
        input signed [17:0] dev;
        input signed [17:0] rate;
        input signed [17:0] sp;
        input signed [17:0] hy;
        input cur;
        input diag;
        input fail;
        reg signed [17:0] adev;
        reg signed [17:0] arate;
        begin
            adev = dev[17] ? -dev : dev;
            arate = rate[17] ? -rate : rate;
            case (typ)
                `LLC_AT_PV_HIGH: alm_eval = cur ? (pv > sp - hy) : (pv > sp);
                `LLC_AT_PV_LOW: alm_eval = cur ? (pv < sp + hy) : (pv < sp);
                `LLC_AT_DEV_HIGH: alm_eval = cur ? (dev > sp - hy) : (dev > sp);
                `LLC_AT_DEV_LOW: alm_eval = cur ? (dev < sp + hy) : (dev < sp);
                `LLC_AT_DEV_OUT: alm_eval = cur ? (adev > sp - hy) : (adev > sp);
                `LLC_AT_DEV_IN: alm_eval = cur ? (adev < sp + hy) : (adev < sp);
                `LLC_AT_RATE: alm_eval = cur ? (arate > sp - hy) : (arate > sp);
                `LLC_AT_DIAG: alm_eval = diag;
                `LLC_AT_FAIL: alm_eval = fail;
                default: alm_eval = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection.

    reg [4:0] pin_meta_reg;
    reg [4:0] pin_sync_reg;
    reg [4:0] pin_prev_reg;
    wire [4:0] pin_rise = pin_sync_reg & ~pin_prev_reg;

    // Two flops on the key and contact pins, then a third stage for edges.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
            pin_prev_reg <= 5'h00;
        end else begin
            pin_meta_reg <= {contact_input, ack_key};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time base.

    reg [31:0] tick_cnt_reg;
    reg tick_reg;

    // One-cycle tick every TICK_CYCLES clocks.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TICK_CYCLES - 1) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
            tick_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers and bus state.

    reg [2:0] ctrl_reg;
    reg [15:0] setpoint_reg;
    reg [31:0] exceed_time_reg;
    reg [15:0] peak_reg;
    reg [4:0] irq_status_reg;
    reg [4:0] irq_mask_reg;
    reg [11:0] di_cfg_reg;
    reg [31:0] alm_cfg_reg [0:NUM_ALARMS-1];
    reg [15:0] alm_sp_reg [0:NUM_ALARMS-1];
    reg [31:0] readdata_reg;
    reg waitrequest_reg;
    reg exceed_reg;
    reg trip_reg;
    reg relay_reg;
    reg [2:0] alarm_out_reg;
    reg pv_red_reg;
    reg backlight_reg;
    reg [2:0] message_reg;
    reg irq_reg;
    reg [15:0] pv_prev_reg;
    reg [16:0] rate_reg;

    // A request completes at the edge where waitrequest is seen low.
    wire bus_done = (avs_read || avs_write) && !waitrequest_reg;
    wire wr_en = avs_write && bus_done;
    wire rd_en = avs_read && bus_done;
    wire [3:0] word_idx = avs_address[5:2];

    ////////////////////////////////////////////////////////////////////////////
    // Limit function.

    wire signed [17:0] pv_ext = {{2{process_value[15]}}, process_value};
    wire signed [17:0] sp_ext = {{2{setpoint_reg[15]}}, setpoint_reg};
    wire signed [17:0] dev_ext = pv_ext - sp_ext;
    wire signed [17:0] rate_ext = {rate_reg[16], rate_reg};
    wire low_mode = ctrl_reg[`LLC_CTRL_LOW_MODE];
    wire exceed_now = low_mode ? (pv_ext < sp_ext) : (pv_ext > sp_ext);
    wire ack_pulse = ctrl_reg[`LLC_CTRL_ACK_SRC] ? pin_rise[1] : pin_rise[0];
    wire [2:0] di_rise = pin_rise[4:2];
    wire alm_release = (wr_en && word_idx == `LLC_OFS_CTRL / 4 && avs_writedata[`LLC_CTRL_ALM_RELEASE])
        || di_has(di_cfg_reg, di_rise, `LLC_DI_ALM_RELEASE);
    reg trip_next;

    // Trip sets with exceed, and clears only on acknowledge while normal.
    always @* begin
        trip_next = trip_reg;
        if (exceed_now) begin
            trip_next = 1'b1;
        end else if (ack_pulse) begin
            trip_next = 1'b0;
        end
    end

    // Exceed indicator, trip latch and relay drive.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            exceed_reg <= 1'b0;
            trip_reg <= 1'b0;
            relay_reg <= 1'b0;
        end else begin
            exceed_reg <= exceed_now;
            trip_reg <= trip_next;
            relay_reg <= !trip_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alarms.

    wire [NUM_ALARMS-1:0] alm_on;
    wire [NUM_ALARMS-1:0] alm_on_rise = alm_on & ~alarm_out_reg;

    genvar g;
    generate
        for (g = 0; g < NUM_ALARMS; g = g + 1) begin : alm
            wire [31:0] cfg = alm_cfg_reg[g];
            wire [3:0] typ = cfg[`LLC_ALM_TYPE_MSB:0];
            wire signed [17:0] sp = {{2{alm_sp_reg[g][15]}}, alm_sp_reg[g]};
            wire signed [17:0] hy = {10'h000, cfg[`LLC_ALM_HYST_LSB +: 8]};
            wire [7:0] on_dly = cfg[`LLC_ALM_ON_LSB +: 8];
            wire [7:0] off_dly = cfg[`LLC_ALM_OFF_LSB +: 8];
            reg raw_reg;
            reg stby_reg;
            reg qual_reg;
            reg lat_reg;
            reg [7:0] dly_cnt_reg;
            wire cond = alm_eval(typ, pv_ext, dev_ext, rate_ext, sp, hy, raw_reg, self_diag_fault, input_fail);
            wire eff = cond && !(cfg[`LLC_ALM_STANDBY] && stby_reg);
            wire [7:0] dly = qual_reg ? off_dly : on_dly;

            // Hysteresis state, standby, on/off delay and latch of one alarm.
            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    raw_reg <= 1'b0;
                    stby_reg <= 1'b1;
                    qual_reg <= 1'b0;
                    lat_reg <= 1'b0;
                    dly_cnt_reg <= 8'h00;
                end else begin
                    raw_reg <= cond;
                    if (!cond) begin
                        stby_reg <= 1'b0;
                    end
                    if (eff == qual_reg) begin
                        dly_cnt_reg <= 8'h00;
                    end else if (dly == 8'h00) begin
                        qual_reg <= eff;
                    end else if (tick_reg) begin
                        if (dly_cnt_reg + 8'h01 >= dly) begin
                            qual_reg <= eff;
                            dly_cnt_reg <= 8'h00;
                        end else begin
                            dly_cnt_reg <= dly_cnt_reg + 8'h01;
                        end
                    end
                    if (!cfg[`LLC_ALM_LATCH]) begin
                        lat_reg <= 1'b0;
                    end else if (qual_reg) begin
                        lat_reg <= 1'b1;
                    end else if (alm_release) begin
                        lat_reg <= 1'b0;
                    end
                end
            end
            assign alm_on[g] = qual_reg || lat_reg;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, contact functions, accumulators and interrupt.

    wire [4:0] irq_set = {alm_on_rise, exceed_now && !exceed_reg, trip_next && !trip_reg};
    wire irq_rd_clear = rd_en && word_idx == `LLC_OFS_IRQ_STATUS / 4;
    wire [4:0] irq_status_next = (irq_rd_clear ? 5'h00 : irq_status_reg) | irq_set;
    reg [2:0] msg_next;
    integer m;

    // Message follows the last message contact raised.
    always @* begin
        msg_next = message_reg;
        for (m = 0; m < 4; m = m + 1) begin
            if (di_has(di_cfg_reg, di_rise, `LLC_DI_MSG1 + m[2:0])) begin
                msg_next = m[2:0] + 3'h1;
            end
        end
    end

    // Registered outputs and the things the block measures.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            alarm_out_reg <= 3'h0;
            pv_red_reg <= 1'b0;
            backlight_reg <= 1'b1;
            message_reg <= 3'h0;
            irq_status_reg <= 5'h00;
            irq_reg <= 1'b0;
            exceed_time_reg <= 32'h00000000;
            peak_reg <= `LLC_RST_PEAK;
            pv_prev_reg <= 16'h0000;
            rate_reg <= 17'h00000;
        end else begin
            alarm_out_reg <= alm_on;
            if (di_has(di_cfg_reg, di_rise, `LLC_DI_PV_COLOUR)) begin
                pv_red_reg <= !pv_red_reg;
            end
            if (di_has(di_cfg_reg, di_rise, `LLC_DI_BACKLIGHT)) begin
                backlight_reg <= !backlight_reg;
            end
            message_reg <= msg_next;
            irq_status_reg <= irq_status_next;
            irq_reg <= |(irq_status_next & irq_mask_reg);
            if (tick_reg) begin
                pv_prev_reg <= process_value;
                rate_reg <= pv_ext[16:0] - {pv_prev_reg[15], pv_prev_reg};
            end
            if (wr_en && word_idx == `LLC_OFS_EXCEED_TIME / 4) begin
                exceed_time_reg <= 32'h00000000;
            end else if (tick_reg && exceed_reg && exceed_time_reg != 32'hffffffff) begin
                exceed_time_reg <= exceed_time_reg + 32'h00000001;
            end
            if (wr_en && word_idx == `LLC_OFS_PEAK / 4) begin
                peak_reg <= `LLC_RST_PEAK;
            end else if ($signed(process_value) > $signed(peak_reg)) begin
                peak_reg <= process_value;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then completion.

    integer a;
    reg [31:0] rd_mux;

    // Read multiplexer; address bit 6 is not decoded, unmapped word indices read zero.
    always @* begin
        rd_mux = 32'h00000000;
        case (word_idx)
            `LLC_OFS_CTRL / 4: rd_mux = {30'h00000000, ctrl_reg[1:0]};
            `LLC_OFS_SETPOINT / 4: rd_mux = {16'h0000, setpoint_reg};
            `LLC_OFS_STATUS / 4: rd_mux = {24'h000000, backlight_reg, pv_red_reg, alarm_out_reg,
                relay_reg, trip_reg, exceed_reg};
            `LLC_OFS_EXCEED_TIME / 4: rd_mux = exceed_time_reg;
            `LLC_OFS_PEAK / 4: rd_mux = {16'h0000, peak_reg};
            `LLC_OFS_IRQ_STATUS / 4: rd_mux = {27'h0000000, irq_status_reg};
            `LLC_OFS_IRQ_MASK / 4: rd_mux = {27'h0000000, irq_mask_reg};
            `LLC_OFS_DI_CFG / 4: rd_mux = {20'h00000, di_cfg_reg};
            default: begin
                for (a = 0; a < NUM_ALARMS; a = a + 1) begin
                    if (word_idx == `LLC_OFS_ALM_CFG0 / 4 + a) begin
                        rd_mux = alm_cfg_reg[a];
                    end
                    if (word_idx == `LLC_OFS_ALM_SP0 / 4 + a) begin
                        rd_mux = {16'h0000, alm_sp_reg[a]};
                    end
                end
            end
        endcase
    end

    // Handshake, read data capture and register writes.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            waitrequest_reg <= 1'b1;
            readdata_reg <= 32'h00000000;
            ctrl_reg <= `LLC_RST_CTRL;
            setpoint_reg <= `LLC_RST_SETPOINT;
            irq_mask_reg <= 5'h00;
            di_cfg_reg <= `LLC_RST_DI_CFG;
            for (a = 0; a < NUM_ALARMS; a = a + 1) begin
                alm_cfg_reg[a] <= `LLC_RST_ALM_CFG;
                alm_sp_reg[a] <= `LLC_RST_ALM_SP;
            end
        end else begin
            waitrequest_reg <= !((avs_read || avs_write) && waitrequest_reg);
            if (avs_read && waitrequest_reg) begin
                readdata_reg <= rd_mux;
            end
            if (wr_en) begin
                case (word_idx)
                    `LLC_OFS_CTRL / 4: ctrl_reg <= {1'b0, avs_writedata[1:0]};
                    `LLC_OFS_SETPOINT / 4: setpoint_reg <= avs_writedata[15:0];
                    `LLC_OFS_IRQ_MASK / 4: irq_mask_reg <= avs_writedata[4:0];
                    `LLC_OFS_DI_CFG / 4: di_cfg_reg <= avs_writedata[11:0];
                    default: begin
                        for (a = 0; a < NUM_ALARMS; a = a + 1) begin
                            if (word_idx == `LLC_OFS_ALM_CFG0 / 4 + a) begin
                                alm_cfg_reg[a] <= avs_writedata;
                            end
                            if (word_idx == `LLC_OFS_ALM_SP0 / 4 + a) begin
                                alm_sp_reg[a] <= avs_writedata[15:0];
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Every output comes from a flip-flop, relay_nc_closed through an inverter.
    assign avs_readdata = readdata_reg;
    assign avs_waitrequest = waitrequest_reg;
    assign exceed_lamp = exceed_reg;
    assign trip_lamp = trip_reg;
    assign relay_energize = relay_reg;
    assign relay_nc_closed = !relay_reg;
    assign relay_no_closed = relay_reg;
    assign alarm_out = alarm_out_reg;
    assign pv_red = pv_red_reg;
    assign backlight_on = backlight_reg;
    assign message_sel = message_reg;
    assign irq = irq_reg;

endmodule

`default_nettype wire

// [llc_chk_sva.sv]
// Concurrent checks on the pins of the latching limit controller.
`default_nettype none
module llc_chk (
    input wire logic ref_clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic avs_read, // Read request.
    input wire logic avs_write, // Write request.
    input wire logic avs_waitrequest, // Bus stall.
    input wire logic exceed_lamp, // Exceed lamp.
    input wire logic trip_lamp, // Trip lamp.
    input wire logic relay_energize, // Relay coil.
    input wire logic relay_nc_closed, // Closed-at-rest contact.
    input wire logic relay_no_closed, // Open-at-rest contact.
    input wire logic [2:0] message_sel // Message choice.
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock; off in reset.
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_RELAY_TRIP: assert property (!$past(rst) |-> relay_energize == !trip_lamp)
        else $error("relay vs trip");
    AST_CONTACTS: assert property (relay_nc_closed == !relay_energize && relay_no_closed == relay_energize)
        else $error("contacts vs coil");
    AST_TRIP_RELAY: assert property ($rose(trip_lamp) |-> !relay_energize)
        else $error("relay on at trip");
    AST_EXCEED_TRIP: assert property (exceed_lamp |-> trip_lamp)
        else $error("exceed without trip");
    AST_TRIP_RISE: assert property ($rose(trip_lamp) |-> exceed_lamp)
        else $error("trip without exceed");
    AST_TRIP_FALL: assert property ($fell(trip_lamp) |-> !exceed_lamp && relay_energize)
        else $error("trip cleared while beyond");
    AST_MSG_RANGE: assert property (message_sel <= 3'h4)
        else $error("message range");
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("wait not one cycle");
endmodule

////////////////////////////////////////////////////////////////////////////////
bind llc_top llc_chk chk (.ref_clk(ref_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .exceed_lamp(exceed_lamp), .trip_lamp(trip_lamp),
    .relay_energize(relay_energize), .relay_nc_closed(relay_nc_closed), .relay_no_closed(relay_no_closed),
    .message_sel(message_sel));
`default_nettype wire

// [llc_field.sv]
// Model of the process sensor, the front key and the contact inputs.
`default_nettype none
module llc_field (
    input wire logic ref_clk, // Clock.
    output logic [15:0] process_value, // Sensor reading.
    output logic ack_key, // Front key.
    output logic [3:0] contact_input // Contact pins.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle: reading zero, key and contacts released.
    initial begin
        process_value = 16'h0000;
        ack_key = 1'b0;
        contact_input = 4'h0;
    end
    // New reading at an edge, then four cycles.
    task automatic set_pv(input logic [15:0] v);
        @(posedge ref_clk);
        process_value <= v;
        repeat (4) @(posedge ref_clk);
    endtask
    // Four-cycle press; bit 4 is the key.
    task automatic press(input logic [4:0] which);
        @(posedge ref_clk);
        {ack_key, contact_input} <= which;
        repeat (4) @(posedge ref_clk);
        {ack_key, contact_input} <= 5'h00;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// [llc_tb.sv]
// Self-checking bench for the latching limit controller.
`default_nettype none
`include "llc_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] avs_address = 7'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic self_diag_fault = 1'b0, input_fail = 1'b0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, ack_key, exceed_lamp, trip_lamp, relay_energize, relay_nc_closed, relay_no_closed;
    logic pv_red, backlight_on, irq;
    logic [15:0] process_value, sp, mx, v;
    logic [3:0] contact_input;
    logic [2:0] alarm_out, message_sel;
    int n_fail = 0;
    int cmp_count = 0;
    always #5 ref_clk = ~ref_clk;
    llc_top #(.TICK_CYCLES(10)) dut (.*);
    llc_field fld (.ref_clk(ref_clk), .process_value(process_value), .ack_key(ack_key),
        .contact_input(contact_input));
    ////////////////////////////////////////////////////////////////////////////
    // Compares 1 ns after the edge.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        #1;
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One transfer, held until waitrequest is low.
    task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            complete_run();
        end
    endtask
    // A value just beyond the setpoint.
    function automatic logic [15:0] beyond(input int low, input logic [15:0] s);
        return low ? s - 16'h1 : s + 16'h1;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        void'($urandom(32'h8550));
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        bus(1'b0, `LLC_OFS_STATUS, 32'h0);
        chk("status", q[7:0], 8'h84);
        bus(1'b0, 7'h3c, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("reset test done");
        // High, then low mode; setpoint falls so no trip.
        for (int m = 0; m < 2; m++) begin
            sp = 16'(100 + (1 - m) * 1000 + $urandom_range(800));
            bus(1'b1, `LLC_OFS_CTRL, 32'(m));
            bus(1'b1, `LLC_OFS_SETPOINT, {16'h0, sp});
            bus(1'b1, `LLC_OFS_IRQ_MASK, 32'h1);
            fld.set_pv(sp);
            chk("lamps at setpoint", {relay_energize, trip_lamp, exceed_lamp}, 3'b100);
            bus(1'b0, `LLC_OFS_IRQ_STATUS, 32'h0);
            fld.set_pv(beyond(m, sp));
            chk("lamps beyond", {relay_energize, trip_lamp, exceed_lamp}, 3'b011);
            chk("contacts", {relay_nc_closed, relay_no_closed}, 2'b10);
            chk("irq on trip", irq, 1'b1);
            fld.press(5'h10);
            chk("early key", {relay_energize, trip_lamp, exceed_lamp}, 3'b011);
            fld.set_pv(sp);
            chk("normal", {relay_energize, trip_lamp, exceed_lamp}, 3'b010);
            bus(1'b0, `LLC_OFS_IRQ_STATUS, 32'h0);
            chk("irq status", q[1:0], 2'b11);
            fld.press(5'h10);
            chk("key", {relay_energize, trip_lamp, exceed_lamp}, 3'b100);
            chk("irq clear", irq, 1'b0);
        end
        $display("limit test done");
        // Contact one acknowledges, not key or contact two.
        bus(1'b1, `LLC_OFS_CTRL, 32'h3);
        fld.set_pv(sp - 16'h1);
        fld.set_pv(sp);
        fld.press(5'h10);
        chk("key ack", trip_lamp, 1'b1);
        fld.press(5'h02);
        chk("contact two", trip_lamp, 1'b1);
        fld.press(5'h01);
        chk("contact one", trip_lamp, 1'b0);
        $display("acknowledge source test done");
        // About twenty ticks beyond.
        bus(1'b1, `LLC_OFS_EXCEED_TIME, 32'h0);
        fld.set_pv(sp - 16'h1);
        repeat (196) @(posedge ref_clk);
        fld.set_pv(sp);
        bus(1'b0, `LLC_OFS_EXCEED_TIME, 32'h0);
        chk("exceed ticks", q >= 19 && q <= 22, 1'b1);
        $display("exceed time test done");
        // Peak: highest signed value since clear.
        bus(1'b1, `LLC_OFS_PEAK, 32'h0);
        mx = sp;
        for (int i = 0; i < 20; i++) begin
            v = 16'($urandom);
            fld.set_pv(v);
            if ($signed(v) > $signed(mx)) begin
                mx = v;
            end
        end
        bus(1'b0, `LLC_OFS_PEAK, 32'h0);
        chk("peak", q[15:0], mx);
        $display("peak test done");
        // Value high, value low and diagnosis alarms, then failure.
        for (int n = 0; n < 3; n++) begin
            bus(1'b1, 7'(`LLC_OFS_ALM_CFG0 + 4 * n), n == 2 ? 32'(`LLC_AT_DIAG) : 32'(n + 1));
            bus(1'b1, 7'(`LLC_OFS_ALM_SP0 + 4 * n), 32'd50);
        end
        self_diag_fault <= 1'b1;
        fld.set_pv(16'd100);
        chk("alarms high", alarm_out, 3'b101);
        self_diag_fault <= 1'b0;
        fld.set_pv(16'd0);
        chk("alarms low", alarm_out, 3'b010);
        bus(1'b1, `LLC_OFS_ALM_CFG0, 32'(`LLC_AT_FAIL));
        input_fail <= 1'b1;
        fld.set_pv(16'd0);
        chk("fail alarm", alarm_out, 3'b011);
        input_fail <= 1'b0;
        $display("alarm test done");
        // Inputs two to four: colour, backlight and message two.
        bus(1'b1, `LLC_OFS_DI_CFG, 32'h0532);
        fld.press(5'h02);
        fld.press(5'h04);
        fld.press(5'h08);
        chk("display", {pv_red, backlight_on, message_sel}, {1'b1, 1'b0, 3'h2});
        $display("contact input test done");
        complete_run();
    end
endmodule
`default_nettype wire
